// ### rtl/pxc_pll_ctrl.sv
// pll register file, enable staging, lock status and apb slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pxc_pll_ctrl
  import pxc_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pxc_pkg::APB_AW-1:0] PADDR,
  input wire logic [pxc_pkg::APB_DW-1:0] PWDATA,
  output logic [pxc_pkg::APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] FIXED_FREQ_SELECT_INPUTS,
  output pxc_pkg::pxc_pll_cfg_t PIX_PLL_CFG,
  output pxc_pkg::pxc_pll_cfg_t LOOP_PLL_CFG,
  output logic [2:0] LOOP_Q,
  output logic CLK_SRC_PIXEL,
  output logic VIDEO_CLOCK_OUTPUT_EN,
  output logic IRQ
);
  import pxc_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // next divider selection after one data access, status holds
  function automatic pxc_sel_t sel_step(input pxc_sel_t s);
    case (s)
      SEL_N: sel_step = SEL_M;
      SEL_M: sel_step = SEL_P;
      SEL_P: sel_step = SEL_N;
      default: sel_step = SEL_STAT;
    endcase
  endfunction

  // data byte seen through a pll data index
  function automatic logic [7:0] sel_read(input pxc_sel_t s, input pxc_pll_cfg_t c,
                                          input logic lk);
    logic [7:0] st;
    st = BYTE_ZERO;
    st[STAT_LOCK_BIT] = lk;
    case (s)
      SEL_N: sel_read = c.n;
      SEL_M: sel_read = c.m;
      SEL_P: sel_read = c.p;
      default: sel_read = st;
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] clk_src_q;
  logic [7:0] mem_loop_q;
  pxc_sel_t pix_sel_q;
  pxc_sel_t loop_sel_q;
  logic [1:0] mclk_sel_q;
  pxc_pll_cfg_t pix_q;
  pxc_pll_cfg_t loop_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [APB_DW-1:0] prdata_q;
  logic pix_lock_d1_q;
  logic loop_lock_d1_q;
  logic sel_1x_d1_q;
  logic [1:0] fsel;
  logic sel_1x;
  logic pix_locked;
  logic loop_locked;
  logic [7:0] idx;
  logic hit;
  logic acc;
  logic wr;
  logic rd;
  logic setup_rd;
  logic [7:0] wbyte;
  logic pix_div_wr;
  logic loop_div_wr;
  logic [IRQ_W-1:0] irq_set;
  logic [7:0] rd_byte;

  // ****************************************************************
  // pins and lock models
  // ****************************************************************
  pxc_pin_sync #(.W(2)) u_fsel_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .pin(FIXED_FREQ_SELECT_INPUTS),
    .val(fsel)
  );
  assign sel_1x = fsel[1];

  pxc_lock_timer #(.CYC(LOCK_CYCLES)) u_pix_lock (
    .clk(REF_CLK),
    .srst(SRST),
    .run(pix_q.run),
    .restart(pix_div_wr),
    .locked(pix_locked)
  );

  pxc_lock_timer #(.CYC(LOCK_CYCLES)) u_loop_lock (
    .clk(REF_CLK),
    .srst(SRST),
    .run(loop_q.run),
    .restart(loop_div_wr),
    .locked(loop_locked)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // index from word address, byte lanes and top bits must be zero
  assign idx = PADDR[9:2];
  assign wbyte = PWDATA[7:0];
  always_comb begin
    if (PADDR[1:0] != APB_LANE_ZERO || PADDR[11:10] != APB_TOP_ZERO) begin
      hit = 1'b0;
    end else if (idx == IDX_CLK_SRC || idx == IDX_PLL_PTR) begin
      hit = 1'b1;
    end else if (idx == IDX_PIX_DATA || idx == IDX_LOOP_DATA) begin
      hit = 1'b1;
    end else if (idx == IDX_MEM_LOOP || idx == IDX_IRQ_STAT) begin
      hit = 1'b1;
    end else if (idx == IDX_IRQ_MASK) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end
  assign acc = PSEL && PENABLE && hit;
  assign wr = acc && PWRITE;
  assign rd = acc && !PWRITE;
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign pix_div_wr = wr && idx == IDX_PIX_DATA && pix_sel_q != SEL_STAT;
  assign loop_div_wr = wr && idx == IDX_LOOP_DATA && loop_sel_q != SEL_STAT;
  assign PREADY = 1'b1; // zero wait states
  assign PSLVERR = PSEL && PENABLE && !hit;

  // ****************************************************************
  // plain registers
  // ****************************************************************
  // clock source and memory/loop clock control
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      clk_src_q <= RST_CLK_SRC;
      mem_loop_q <= RST_BYTE;
    end else if (wr && idx == IDX_CLK_SRC) begin
      clk_src_q <= wbyte;
    end else if (wr && idx == IDX_MEM_LOOP) begin
      mem_loop_q <= wbyte;
    end
  end
  assign CLK_SRC_PIXEL = (clk_src_q[3:0] == SRC_NIB_PIX);
  assign VIDEO_CLOCK_OUTPUT_EN = (clk_src_q[6:4] != VIDEO_CLOCK_OUTPUT_OFF_PAT);
  assign LOOP_Q = mem_loop_q[2:0];

  // ****************************************************************
  // pll address pointer
  // ****************************************************************
  // pointer load sets each pll field; data accesses step its field
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pix_sel_q <= SEL_N;
      loop_sel_q <= SEL_N;
      mclk_sel_q <= 2'h0;
    end else if (wr && idx == IDX_PLL_PTR) begin
      pix_sel_q <= pxc_sel_t'(wbyte[1:0]);
      mclk_sel_q <= wbyte[3:2];
      loop_sel_q <= pxc_sel_t'(wbyte[5:4]);
    end else if (acc && idx == IDX_PIX_DATA) begin
      pix_sel_q <= sel_step(pix_sel_q);
    end else if (acc && idx == IDX_LOOP_DATA) begin
      loop_sel_q <= sel_step(loop_sel_q);
    end
  end

  // ****************************************************************
  // divider registers and staged enables
  // ****************************************************************
  // pixel pll dividers; run follows p enable only while select is 1x
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pix_q <= '0;
    end else begin
      if (pix_div_wr && pix_sel_q == SEL_N) begin
        pix_q.n <= wbyte;
      end
      if (pix_div_wr && pix_sel_q == SEL_M) begin
        pix_q.m <= wbyte;
      end
      if (pix_div_wr && pix_sel_q == SEL_P) begin
        pix_q.p <= wbyte;
      end
      if (sel_1x) begin
        pix_q.run <= pix_q.p[P_RUN_BIT];
      end
    end
  end

  // loop pll dividers, same staging
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      loop_q <= '0;
    end else begin
      if (loop_div_wr && loop_sel_q == SEL_N) begin
        loop_q.n <= wbyte;
      end
      if (loop_div_wr && loop_sel_q == SEL_M) begin
        loop_q.m <= wbyte;
      end
      if (loop_div_wr && loop_sel_q == SEL_P) begin
        loop_q.p <= wbyte;
      end
      if (sel_1x) begin
        loop_q.run <= loop_q.p[P_RUN_BIT];
      end
    end
  end
  assign PIX_PLL_CFG = pix_q;
  assign LOOP_PLL_CFG = loop_q;

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // edge history for lock rises and entry into 1x
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pix_lock_d1_q <= 1'b0;
      loop_lock_d1_q <= 1'b0;
      sel_1x_d1_q <= 1'b0;
    end else begin
      pix_lock_d1_q <= pix_locked;
      loop_lock_d1_q <= loop_locked;
      sel_1x_d1_q <= sel_1x;
    end
  end
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_PIX_LOCK] = pix_locked && !pix_lock_d1_q;
    irq_set[IRQ_LOOP_LOCK] = loop_locked && !loop_lock_d1_q;
    irq_set[IRQ_APPLY] = sel_1x && !sel_1x_d1_q;
  end

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      irq_stat_q <= '0;
    end else if (wr && idx == IDX_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~wbyte[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // interrupt mask
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      irq_mask_q <= '0;
    end else if (wr && idx == IDX_IRQ_MASK) begin
      irq_mask_q <= wbyte[IRQ_W-1:0];
    end
  end
  assign IRQ = |(irq_stat_q & irq_mask_q);

  // ****************************************************************
  // read data
  // ****************************************************************
  // byte for the addressed register, sampled in the setup cycle
  always_comb begin
    rd_byte = BYTE_ZERO;
    if (idx == IDX_CLK_SRC) begin
      rd_byte = clk_src_q;
    end else if (idx == IDX_PLL_PTR) begin
      rd_byte = {2'h0, loop_sel_q, mclk_sel_q, pix_sel_q};
    end else if (idx == IDX_PIX_DATA) begin
      rd_byte = sel_read(pix_sel_q, pix_q, pix_locked);
    end else if (idx == IDX_LOOP_DATA) begin
      rd_byte = sel_read(loop_sel_q, loop_q, loop_locked);
    end else if (idx == IDX_MEM_LOOP) begin
      rd_byte = mem_loop_q;
    end else if (idx == IDX_IRQ_STAT) begin
      rd_byte[IRQ_W-1:0] = irq_stat_q;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_byte[IRQ_W-1:0] = irq_mask_q;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      prdata_q <= '0;
    end else if (setup_rd) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end
  assign PRDATA = prdata_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  enable_apply_a: assert property (sel_1x |=> pix_q.run == $past(pix_q.p[P_RUN_BIT]))
    else $error("pixel enable not applied in 1x");
  enable_hold_a: assert property (!sel_1x |=> $stable(pix_q.run) && $stable(loop_q.run))
    else $error("enable changed outside 1x");
  ptr_p_sel_a: assert property (wr && idx == IDX_PLL_PTR && wbyte == PTR_ALL_P
    |=> pix_sel_q == SEL_P && loop_sel_q == SEL_P)
    else $error("pointer 2A did not select P");
  ptr_n_walk_a: assert property (acc && idx == IDX_PIX_DATA && pix_sel_q == SEL_N
    |=> pix_sel_q == SEL_M)
    else $error("pixel N did not step to M");
  ptr_m_walk_a: assert property (acc && idx == IDX_LOOP_DATA && loop_sel_q == SEL_M
    |=> loop_sel_q == SEL_P)
    else $error("loop M did not step to P");
  ptr_stat_a: assert property (wr && idx == IDX_PLL_PTR && wbyte == PTR_ALL_STAT
    |=> pix_sel_q == SEL_STAT && loop_sel_q == SEL_STAT)
    else $error("pointer 3F did not select status");
  stat_hold_a: assert property (acc && idx == IDX_LOOP_DATA && loop_sel_q == SEL_STAT
    |=> loop_sel_q == SEL_STAT)
    else $error("status selection not held");
  pix_lock_rd_a: assert property (setup_rd && hit && idx == IDX_PIX_DATA
    && pix_sel_q == SEL_STAT |=> PRDATA[STAT_LOCK_BIT] == $past(pix_locked))
    else $error("pixel lock bit wrong");
  loop_lock_a: assert property ($rose(loop_locked) |-> $past(loop_q.run, 2))
    else $error("loop lock without running");
  clk_src_a: assert property (wr && idx == IDX_CLK_SRC && wbyte == SRC_PIX_VIDEO_CLOCK_OUTPUT_OFF
    |=> CLK_SRC_PIXEL)
    else $error("0x75 did not pick pixel pll");
  video_clock_output_off_a: assert property (wr && idx == IDX_CLK_SRC && wbyte[6:4] == VIDEO_CLOCK_OUTPUT_OFF_PAT
    |=> !VIDEO_CLOCK_OUTPUT_EN [*2])
    else $error("video clock output not disabled");
  set_wins_a: assert property (irq_set[IRQ_PIX_LOCK] |=> irq_stat_q[IRQ_PIX_LOCK])
    else $error("lock event lost");

  pix_lock_c: cover property ($rose(pix_locked));
  loop_lock_c: cover property ($rose(loop_locked) && pix_locked);
  stop_c: cover property (sel_1x && $fell(pix_q.run));
  irq_c: cover property ($rose(IRQ));
endmodule
`default_nettype wire

// ### rtl/pxc_pkg.sv
// constants and types for the pll extended-mode programming block
package pxc_pkg;
  // ****************************************************************
  // apb geometry
  // ****************************************************************
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam logic [1:0] APB_LANE_ZERO = 2'h0;
  localparam logic [1:0] APB_TOP_ZERO = 2'h0;
  // ****************************************************************
  // register indices, byte address is index times four
  // ****************************************************************
  localparam logic [7:0] IDX_CLK_SRC = 8'h1A;
  localparam logic [7:0] IDX_PLL_PTR = 8'h2C;
  localparam logic [7:0] IDX_PIX_DATA = 8'h2D;
  localparam logic [7:0] IDX_LOOP_DATA = 8'h2F;
  localparam logic [7:0] IDX_MEM_LOOP = 8'h39;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  // ****************************************************************
  // pointer values, fields and reset values
  // ****************************************************************
  localparam logic [7:0] PTR_ALL_N = 8'h00;
  localparam logic [7:0] PTR_ALL_P = 8'h2A;
  localparam logic [7:0] PTR_ALL_STAT = 8'h3F;
  localparam logic [7:0] SRC_PIX_VIDEO_CLOCK_OUTPUT_OFF = 8'h75;
  localparam logic [3:0] SRC_NIB_PIX = 4'h5;
  localparam logic [2:0] VIDEO_CLOCK_OUTPUT_OFF_PAT = 3'h7;
  localparam int P_RUN_BIT = 7;
  localparam int STAT_LOCK_BIT = 6;
  localparam logic [7:0] RST_CLK_SRC = 8'h05;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ****************************************************************
  // interrupt status layout
  // ****************************************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_PIX_LOCK = 0;
  localparam int IRQ_LOOP_LOCK = 1;
  localparam int IRQ_APPLY = 2;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int LOCK_TIME_NS = 10000;
  localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {SEL_N, SEL_M, SEL_P, SEL_STAT} pxc_sel_t;
  typedef struct packed {
    logic run;
    logic [7:0] n;
    logic [7:0] m;
    logic [7:0] p;
  } pxc_pll_cfg_t;
endpackage

// ### rtl/pxc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pxc_pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] val
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] val_q;
  // shift chain, value taken once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      val_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        val_q <= s3_q;
      end
    end
  end
  assign val = val_q;
endmodule
`default_nettype wire

// ### rtl/pxc_lock_timer.sv
// lock model: lock after a settle count of uninterrupted running
`timescale 1ns/1ns
`default_nettype none
module pxc_lock_timer #(
  parameter int CYC = 500
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic restart,
  output logic locked
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_q;
  // count while running, restart on any divider change
  always_ff @(posedge clk) begin
    if (srst || !run || restart) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(CYC)) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
  assign locked = (cnt_q == CW'(CYC));
endmodule
`default_nettype wire

// ### tb/pxc_sel_pins.sv
// partner model: board strap driving the fixed-frequency select pins
`timescale 1ns/1ns
`default_nettype none
module pxc_sel_pins (
  input wire logic clk,
  input wire logic [1:0] want,
  output logic [1:0] pins
);
  initial pins = 2'h0;
  // pins move just after an edge and then hold; 1x applies staged enables
  always @(posedge clk) begin
    pins <= want;
  end
endmodule
`default_nettype wire

// ### tb/pll_extended_mode_programming_bench.sv
// self-checking bench for the pll extended-mode programming block
`timescale 1ns/1ns
`default_nettype none
module pll_extended_mode_programming_bench;
  import pxc_pkg::*;
  localparam int LK = 8;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [1:0] want = 2'h0;
  logic [1:0] pins;
  logic [APB_DW-1:0] prdata;
  logic pready, pslverr, clk_src_pixel, video_clock_output_en, irq;
  logic [2:0] loop_q;
  pxc_pll_cfg_t pix_cfg, loop_cfg;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] r;
  logic e;
  // ****************************************************************
  // clock, partner and design
  // ****************************************************************
  always #10 ref_clk = ~ref_clk;
  pxc_sel_pins u_pxc_sel_pins (.clk(ref_clk), .want(want), .pins(pins));
  pxc_pll_ctrl #(.LOCK_CYCLES(LK)) u_pxc_pll_ctrl (
    .REF_CLK(ref_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FIXED_FREQ_SELECT_INPUTS(pins),
    .PIX_PLL_CFG(pix_cfg), .LOOP_PLL_CFG(loop_cfg), .LOOP_Q(loop_q),
    .CLK_SRC_PIXEL(clk_src_pixel), .VIDEO_CLOCK_OUTPUT_EN(video_clock_output_en), .IRQ(irq)
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, index is a word index
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk); // registers written at the access edge are settled here
  endtask
  // move the select pins and let the synchroniser settle
  task automatic set_pins(input logic [1:0] v);
    @(posedge ref_clk);
    want <= v;
    repeat (7) @(posedge ref_clk);
  endtask
  // bounded poll of a status read for the lock bit
  task automatic poll(input logic [7:0] idx, input string what);
    int k;
    k = 0;
    do begin
      xfer(1'b0, idx, 8'h00);
      k++;
    end while (r[STAT_LOCK_BIT] !== 1'b1 && k < 40);
    chk(what, {24'h0, r}, 32'h40);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // values after reset
  task automatic t_reset;
    xfer(1'b0, IDX_CLK_SRC, 8'h00);
    chk("clk_src_reset", {24'h0, r}, {24'h0, RST_CLK_SRC});
    chk("pready", {31'h0, pready}, 32'h1);
    chk("no_slverr", {31'h0, e}, 32'h0);
    chk("src_pixel_reset", {31'h0, clk_src_pixel}, 32'h1);
    chk("video_clock_output_en_reset", {31'h0, video_clock_output_en}, 32'h1);
    chk("irq_reset", {31'h0, irq}, 32'h0);
  endtask
  // clock source select and video clock disable
  task automatic t_src;
    xfer(1'b1, IDX_CLK_SRC, 8'h77);
    chk("src_other", {31'h0, clk_src_pixel}, 32'h0);
    xfer(1'b1, IDX_CLK_SRC, SRC_PIX_VIDEO_CLOCK_OUTPUT_OFF);
    xfer(1'b0, IDX_CLK_SRC, 8'h00);
    chk("clk_src_rd", {24'h0, r}, 32'h75);
    chk("src_pixel", {31'h0, clk_src_pixel}, 32'h1);
    chk("video_clock_output_off", {31'h0, video_clock_output_en}, 32'h0);
  endtask
  // enables staged until the select pins read 1x
  task automatic t_gate;
    xfer(1'b1, IDX_PLL_PTR, PTR_ALL_P);
    xfer(1'b1, IDX_PIX_DATA, 8'hF0);
    repeat (3) @(posedge ref_clk);
    chk("run_held", {31'h0, pix_cfg.run}, 32'h0);
    chk("p_stored", {24'h0, pix_cfg.p}, 32'hF0);
    set_pins(2'h2);
    chk("run_applied", {31'h0, pix_cfg.run}, 32'h1);
    xfer(1'b1, IDX_IRQ_STAT, 8'h07);
    set_pins(2'h0);
  endtask
  // full extended-mode clock change with both locks
  task automatic t_ext;
    xfer(1'b1, IDX_PLL_PTR, PTR_ALL_P);
    xfer(1'b1, IDX_LOOP_DATA, BYTE_ZERO);
    xfer(1'b1, IDX_PIX_DATA, BYTE_ZERO);
    set_pins(2'h3);
    chk("pix_stopped", {31'h0, pix_cfg.run}, 32'h0);
    chk("loop_stopped", {31'h0, loop_cfg.run}, 32'h0);
    // pixel lock left over from the gate scenario plus the new 1x entry
    xfer(1'b0, IDX_IRQ_STAT, 8'h00);
    chk("apply_event", {29'h0, r[2:0]}, 32'h5);
    xfer(1'b1, IDX_IRQ_STAT, 8'h05);
    xfer(1'b1, IDX_PLL_PTR, PTR_ALL_N);
    xfer(1'b1, IDX_PIX_DATA, 8'hE8);
    xfer(1'b1, IDX_PIX_DATA, 8'h1C);
    xfer(1'b1, IDX_PIX_DATA, 8'hB0);
    @(posedge ref_clk); // run follows the new p one edge later
    chk("pix_cfg", 32'(pix_cfg), {7'h0, 1'b1, 24'hE81CB0});
    xfer(1'b1, IDX_PLL_PTR, PTR_ALL_STAT);
    xfer(1'b0, IDX_PLL_PTR, 8'h00);
    chk("ptr_stat", {24'h0, r}, {24'h0, PTR_ALL_STAT});
    poll(IDX_PIX_DATA, "pix_lock");
    chk("irq_masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, IDX_IRQ_MASK, 8'h01);
    chk("irq_raised", {31'h0, irq}, 32'h1);
    xfer(1'b1, IDX_IRQ_STAT, 8'h01);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    xfer(1'b1, IDX_MEM_LOOP, 8'h35);
    chk("loop_q", {29'h0, loop_q}, 32'h5);
    xfer(1'b1, IDX_PLL_PTR, PTR_ALL_N);
    xfer(1'b1, IDX_LOOP_DATA, 8'hF9);
    xfer(1'b1, IDX_LOOP_DATA, 8'hBE);
    xfer(1'b1, IDX_LOOP_DATA, 8'hF1);
    @(posedge ref_clk); // run follows the new p one edge later
    chk("loop_cfg", 32'(loop_cfg), {7'h0, 1'b1, 24'hF9BEF1});
    xfer(1'b1, IDX_PLL_PTR, PTR_ALL_STAT);
    poll(IDX_LOOP_DATA, "loop_lock");
    xfer(1'b0, IDX_IRQ_STAT, 8'h00);
    chk("loop_lock_event", {29'h0, r[2:0]}, 32'h2);
  endtask
  // unmapped index is refused and has no effect
  task automatic t_bad;
    xfer(1'b1, 8'h10, 8'hAA);
    chk("slverr", {31'h0, e}, 32'h1);
    xfer(1'b0, 8'h10, 8'h00);
    chk("bad_read", {24'h0, r}, 32'h0);
  endtask
  // ****************************************************************
  // verdict, watchdog and main sequence
  // ****************************************************************
  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_src();
    t_gate();
    t_ext();
    t_bad();
    wrap_up();
  end
endmodule
`default_nettype wire
